/* File: common/status_frame_pkg.sv */
/*
 * constants and carrier types for the status frame builder.
 * assumes one 10 MHz clock and byte-wide serial api output downstream.
 */
package status_frame_pkg;

    // ---------------------------------------------------------------
    // frame layout
    // ---------------------------------------------------------------
    localparam logic [7:0]  START_DELIM      = 8'h7e;
    localparam logic [7:0]  TYPE_MODEM       = 8'h8a;
    localparam logic [7:0]  TYPE_TX_EXT      = 8'h8b;
    localparam logic [15:0] LEN_MODEM        = 16'h0002;
    localparam logic [15:0] LEN_TX_EXT       = 16'h0007;
    localparam logic [15:0] RESERVED_ADDR    = 16'hfffe;
    localparam logic [7:0]  CHECKSUM_BASE    = 8'hff;
    localparam logic [3:0]  POS_LEN_HI       = 4'h1;
    localparam logic [3:0]  POS_TYPE         = 4'h3;
    localparam logic [3:0]  POS_FIRST_FIELD  = 4'h4;
    localparam logic [3:0]  POS_RSV_HI       = 4'h5;
    localparam logic [3:0]  POS_RSV_LO       = 4'h6;
    localparam logic [3:0]  POS_RETRY        = 4'h7;
    localparam logic [3:0]  POS_DELIVERY     = 4'h8;
    localparam logic [3:0]  POS_DISCOVERY    = 4'h9;
    localparam logic [3:0]  POS_LAST_MODEM   = 4'h4;
    localparam logic [3:0]  POS_LAST_TX_EXT  = 4'h9;

    // ---------------------------------------------------------------
    // modem status codes
    // ---------------------------------------------------------------
    localparam logic [7:0]  MS_HW_RESET      = 8'h00;
    localparam logic [7:0]  MS_WDT_RESET     = 8'h01;
    localparam logic [7:0]  MS_ID_CONFLICT   = 8'h40;
    localparam logic [7:0]  MS_NET_WDT       = 8'h42;
    localparam logic [7:0]  MS_STACK_ERR_LO  = 8'h80;

    // ---------------------------------------------------------------
    // delivery and discovery status codes
    // ---------------------------------------------------------------
    localparam logic [7:0]  DS_SUCCESS       = 8'h00;
    localparam logic [7:0]  DS_MAC_ACK       = 8'h01;
    localparam logic [7:0]  DS_CCA           = 8'h02;
    localparam logic [7:0]  DS_INDIRECT      = 8'h03;
    localparam logic [7:0]  DS_NET_ACK       = 8'h21;
    localparam logic [7:0]  DS_NO_ROUTE      = 8'h25;
    localparam logic [7:0]  DS_RES_INTERNAL  = 8'h31;
    localparam logic [7:0]  DS_RES_BUFFERS   = 8'h32;
    localparam logic [7:0]  DS_NO_SESSION    = 8'h34;
    localparam logic [7:0]  DS_ENCRYPT       = 8'h35;
    localparam logic [7:0]  DS_TOO_LARGE     = 8'h74;
    localparam logic [7:0]  DS_INDIRECT_UNRQ = 8'h75;
    localparam logic [7:0]  DISC_NONE        = 8'h00;
    localparam logic [7:0]  DISC_ROUTE       = 8'h02;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int          FIFO_DEPTH       = 16;
    localparam int          BYTE_W           = 8;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CAUSE_HW_RESET  = 2'h0,
        CAUSE_WDT_RESET = 2'h1,
        CAUSE_CONFLICT  = 2'h2,
        CAUSE_NET_WDT   = 2'h3
    } modem_cause_e;

    typedef struct packed {
        logic [7:0] frame_id;
        logic       broadcast;
        logic [7:0] retries;
        logic [7:0] delivery;
        logic       route_disc;
    } tx_done_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } api_byte_s;

endpackage : status_frame_pkg

/* File: logic/byte_fifo.sv */
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow : assert property (@(posedge clk) disable iff (reset)
        count_ff <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");

endmodule : byte_fifo

/* File: logic/status_code_map.sv */
/*
 * maps modem causes and transmit results onto status codes.
 * assumes causes and results are from logic on the same clock.
 */
`timescale 1ns/100ps
module status_code_map (
    input  wire status_frame_pkg::modem_cause_e cause,
    input  wire logic                            stack_err,
    input  wire logic [6:0]                      stack_code,
    input  wire status_frame_pkg::tx_done_s      tx_in,
    output logic [7:0]                           modem_code,
    output logic [7:0]                           delivery_code,
    output logic [7:0]                           discovery_code
);
    logic [7:0] cause_code;

    always_comb begin
        case (cause)
            status_frame_pkg::CAUSE_HW_RESET:  cause_code =
                status_frame_pkg::MS_HW_RESET;
            status_frame_pkg::CAUSE_WDT_RESET: cause_code =
                status_frame_pkg::MS_WDT_RESET;
            status_frame_pkg::CAUSE_CONFLICT:  cause_code =
                status_frame_pkg::MS_ID_CONFLICT;
            status_frame_pkg::CAUSE_NET_WDT:   cause_code =
                status_frame_pkg::MS_NET_WDT;
            default: cause_code = status_frame_pkg::MS_HW_RESET;
        endcase
    end

    // stack errors fill the whole upper half of the code space
    assign modem_code = stack_err ?
        (status_frame_pkg::MS_STACK_ERR_LO | {1'b0, stack_code})
        : cause_code;

    // no ack exists for broadcast, so failure cannot be seen
    assign delivery_code = tx_in.broadcast ?
        status_frame_pkg::DS_SUCCESS : tx_in.delivery;

    assign discovery_code = tx_in.route_disc ?
        status_frame_pkg::DISC_ROUTE : status_frame_pkg::DISC_NONE;

endmodule : status_code_map

/* File: logic/status_frame_builder.sv */
/*
 * builds modem status and extended transmit status api frames and
 * streams them bytewise through a fifo to the serial api port.
 * assumes event inputs come from logic on clk; the uart side drains
 * the output stream with valid/ready.
 */
// How it works
// - modem status byte at position 4; 0x00 hw reset, 0x01 watchdog reset.
// - status 0x40 on identifier conflict change, 0x42 on network watchdog.
// - status codes 0x80 to 0xFF mean internal stack error.
// - last byte is 0xFF minus sum of bytes from position 3.
// - after reset send boot frame 7E 00 02 8A 00 75.
// - completed transmission produces a type 0x8B extended status frame.
// - no extended status frame when request frame identifier is zero.
// - broadcast transmissions always report delivery status 0x00.
// - delimiter at position 0, 16-bit length at 1, counting payload.
// - request frame identifier placed at position 4 of extended status.
// - positions 5 and 6 carry the fixed value 0xFFFE.
// - position 7 carries the application retry count.
// - position 8 carries the delivery status code.
// - codes 0x34 and 0x35 report missing session and encryption failure.
// - position 9 carries discovery status 0x00 or 0x02.
`timescale 1ns/100ps
module status_frame_builder #(
    parameter int FIFO_DEPTH = status_frame_pkg::FIFO_DEPTH
) (
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic                            modem_evt,
    input  wire status_frame_pkg::modem_cause_e  modem_cause,
    input  wire logic                            modem_stack_err,
    input  wire logic [6:0]                      modem_stack_code,
    output logic                                 modem_ready,
    input  wire logic                            tx_done,
    input  wire status_frame_pkg::tx_done_s      tx_info,
    output logic                                 tx_ready,
    output status_frame_pkg::api_byte_s          api_out,
    output logic                                 api_valid,
    input  wire logic                            api_ready
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_MODEM = 2'b01,
        ST_TXEXT = 2'b10,
        ST_BOOT  = 2'b11
    } build_e;

    build_e      state_ff;
    build_e      nxt_state;
    logic [3:0]  pos_ff;
    logic [7:0]  sum_ff;
    logic [7:0]  mcode_ff;
    logic [7:0]  fid_ff;
    logic [7:0]  retry_ff;
    logic [7:0]  dcode_ff;
    logic [7:0]  disc_ff;

    logic [7:0]  map_modem;
    logic [7:0]  map_deliv;
    logic [7:0]  map_disc;

    status_code_map u_map (
        .cause          (modem_cause),
        .stack_err      (modem_stack_err),
        .stack_code     (modem_stack_code),
        .tx_in          (tx_info),
        .modem_code     (map_modem),
        .delivery_code  (map_deliv),
        .discovery_code (map_disc)
    );

    // ---------------------------------------------------------------
    // byte selection
    // ---------------------------------------------------------------
    wire        is_tx     = (state_ff == ST_TXEXT);
    wire        busy      = (state_ff != ST_IDLE);
    wire [15:0] frame_len = is_tx ? status_frame_pkg::LEN_TX_EXT
                                  : status_frame_pkg::LEN_MODEM;
    wire [3:0]  last_pos  = is_tx ? status_frame_pkg::POS_LAST_TX_EXT
                                  : status_frame_pkg::POS_LAST_MODEM;
    wire        at_csum   = (pos_ff == last_pos + 4'h1);
    wire [7:0]  csum      = status_frame_pkg::CHECKSUM_BASE - sum_ff;
    logic [7:0] field_byte;

    always_comb begin
        case (pos_ff)
            4'h0: field_byte = status_frame_pkg::START_DELIM;
            status_frame_pkg::POS_LEN_HI:
                field_byte = frame_len[15:8];
            4'h2: field_byte = frame_len[7:0];
            status_frame_pkg::POS_TYPE:
                field_byte = is_tx ? status_frame_pkg::TYPE_TX_EXT
                                   : status_frame_pkg::TYPE_MODEM;
            status_frame_pkg::POS_FIRST_FIELD:
                field_byte = is_tx ? fid_ff : mcode_ff;
            status_frame_pkg::POS_RSV_HI:
                field_byte = status_frame_pkg::RESERVED_ADDR[15:8];
            status_frame_pkg::POS_RSV_LO:
                field_byte = status_frame_pkg::RESERVED_ADDR[7:0];
            status_frame_pkg::POS_RETRY:
                field_byte = retry_ff;
            status_frame_pkg::POS_DELIVERY:
                field_byte = dcode_ff;
            status_frame_pkg::POS_DISCOVERY:
                field_byte = disc_ff;
            default: field_byte = 8'h00;
        endcase
    end

    wire [7:0] cur_byte = at_csum ? csum : field_byte;
    logic      fifo_in_ready;
    wire       emit     = busy && fifo_in_ready;
    wire       frame_end = emit && at_csum;

    // extended status with a zero identifier is consumed silently
    wire tx_drop  = tx_done && (tx_info.frame_id == 8'h00);
    // modem events take priority over transmit completions
    wire take_m   = !busy && modem_evt;
    wire take_tx  = !busy && !modem_evt && tx_done && !tx_drop;

    assign modem_ready = !busy;
    assign tx_ready    = (!busy && !modem_evt) || tx_drop;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take_m) begin
                    nxt_state = ST_MODEM;
                end else if (take_tx) begin
                    nxt_state = ST_TXEXT;
                end
            end
            ST_BOOT, ST_MODEM, ST_TXEXT: begin
                if (frame_end) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_BOOT;
            pos_ff   <= 4'h0;
            sum_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (!busy || frame_end) begin
                pos_ff <= 4'h0;
                sum_ff <= 8'h00;
            end else if (emit) begin
                pos_ff <= pos_ff + 4'h1;
                if (pos_ff >= status_frame_pkg::POS_TYPE) begin
                    sum_ff <= sum_ff + cur_byte;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mcode_ff <= status_frame_pkg::MS_HW_RESET;
            fid_ff   <= 8'h00;
            retry_ff <= 8'h00;
            dcode_ff <= 8'h00;
            disc_ff  <= 8'h00;
        end else if (take_m) begin
            mcode_ff <= map_modem;
        end else if (take_tx) begin
            fid_ff   <= tx_info.frame_id;
            retry_ff <= tx_info.retries;
            dcode_ff <= map_deliv;
            disc_ff  <= map_disc;
        end
    end

    // ---------------------------------------------------------------
    // output buffer
    // ---------------------------------------------------------------
    status_frame_pkg::api_byte_s fifo_in;
    logic [8:0]                  fifo_out;
    assign fifo_in.data = cur_byte;
    assign fifo_in.last = at_csum;
    assign api_out      = fifo_out;

    byte_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (fifo_in),
        .in_valid  (busy),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (api_valid),
        .out_ready (api_ready)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_delim_first : assert property (@(posedge clk) disable iff (reset)
        emit && pos_ff == 4'h0 |-> cur_byte == 8'h7e)
        else $error("frame does not open with delimiter");

    a_csum_value : assert property (@(posedge clk) disable iff (reset)
        emit && at_csum |-> (cur_byte + sum_ff) == 8'hff)
        else $error("checksum does not complete sum to ff");

    a_zero_id_drop : assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && tx_done && tx_info.frame_id == 8'h00
        && !modem_evt |=> state_ff != ST_TXEXT)
        else $error("frame sent for zero identifier");

    a_tx_type : assert property (@(posedge clk) disable iff (reset)
        emit && is_tx && pos_ff == 4'h3 |-> cur_byte == 8'h8b)
        else $error("wrong extended status type");

    a_bcast_ok : assert property (@(posedge clk) disable iff (reset)
        take_tx && tx_info.broadcast |=> dcode_ff == 8'h00)
        else $error("broadcast reported failure");

    a_reserved_fe : assert property (@(posedge clk) disable iff (reset)
        emit && is_tx && pos_ff == 4'h6 |-> cur_byte == 8'hfe)
        else $error("reserved low byte not fe");

    a_len_hi_first : assert property (@(posedge clk) disable iff (reset)
        emit && pos_ff == 4'h1 |-> cur_byte == 8'h00)
        else $error("length high byte not zero");

    a_fid_echo : assert property (@(posedge clk) disable iff (reset)
        take_tx |=> fid_ff == $past(tx_info.frame_id))
        else $error("frame identifier not captured");

    a_boot_first : assert property (@(posedge clk)
        $fell(reset) |-> state_ff == ST_BOOT && mcode_ff == 8'h00)
        else $error("boot frame not pending after reset");

    a_modem_len : assert property (@(posedge clk) disable iff (reset)
        emit && !is_tx && pos_ff == 4'h2 |-> cur_byte == 8'h02)
        else $error("modem length not two");

    c_boot_done : cover property (@(posedge clk) disable iff (reset)
        frame_end && state_ff == ST_BOOT);
    c_tx_frame : cover property (@(posedge clk) disable iff (reset)
        frame_end && is_tx);
    c_zero_drop : cover property (@(posedge clk) disable iff (reset)
        tx_drop && !busy);
    c_fifo_full : cover property (@(posedge clk) disable iff (reset)
        busy && !fifo_in_ready);

endmodule : status_frame_builder

/* File: tb/api_sink.sv */
/*
 * host model: drains the api byte stream, can stall or trickle.
 * assumes one clock; ready moves only on the falling edge.
 */
`timescale 1ns/100ps
module api_sink (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire status_frame_pkg::api_byte_s api_out,
    input  wire logic                        api_valid,
    output logic                             api_ready,
    input  wire logic                        hold,
    input  wire logic                        slow,
    output logic                             bad_frame
);
    // ---------------------------------------------------------------
    // ready pacing and framing check
    // ---------------------------------------------------------------
    logic [1:0] cnt_ff;
    logic [3:0] pos_ff;
    logic [7:0] sum_ff;

    // slow mode takes one byte in four so the fifo backs up
    always @(negedge clk) begin
        if (reset) begin
            cnt_ff <= 2'h0;
            api_ready <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            api_ready <= !hold && (!slow || cnt_ff == 2'h0);
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            pos_ff <= 4'h0;
            sum_ff <= 8'h00;
            bad_frame <= 1'b0;
        end else if (api_valid && api_ready) begin
            if (api_out.last) begin
                if (8'(sum_ff + api_out.data) != 8'hff)
                    bad_frame <= 1'b1;
                pos_ff <= 4'h0;
                sum_ff <= 8'h00;
            end else begin
                if (pos_ff >= 4'h3)
                    sum_ff <= sum_ff + api_out.data;
                if (pos_ff == 4'h0 && api_out.data != 8'h7e)
                    bad_frame <= 1'b1;
                pos_ff <= pos_ff + 4'h1;
            end
        end
    end
endmodule : api_sink

/* File: tb/tb_top.sv */
/*
 * self-checking bench for the status frame builder.
 * assumes the builder and fifo from logic/ and the host model api_sink.
 */
`timescale 1ns/100ps
module tb_top;
    logic                            clk;
    logic                            reset;
    logic                            modem_evt;
    status_frame_pkg::modem_cause_e  modem_cause;
    logic                            modem_stack_err;
    logic [6:0]                      modem_stack_code;
    logic                            modem_ready;
    logic                            tx_done;
    status_frame_pkg::tx_done_s      tx_info;
    logic                            tx_ready;
    status_frame_pkg::api_byte_s     api_out;
    logic                            api_valid;
    logic                            api_ready;
    logic                            hold;
    logic                            slow;
    logic                            bad_frame;
    logic [8:0]                      exp_q[$];
    int                              n_errors;
    int                              check_count;
    int                              cycles;
    int                              seed;
    logic [7:0]                      dtab[12] = '{8'h00, 8'h01, 8'h02,
        8'h03, 8'h21, 8'h25, 8'h31, 8'h32, 8'h34, 8'h35, 8'h74, 8'h75};

    status_frame_builder status_frame_builder_i (.clk(clk), .reset(reset),
        .modem_evt(modem_evt), .modem_cause(modem_cause),
        .modem_stack_err(modem_stack_err),
        .modem_stack_code(modem_stack_code), .modem_ready(modem_ready),
        .tx_done(tx_done), .tx_info(tx_info), .tx_ready(tx_ready),
        .api_out(api_out), .api_valid(api_valid), .api_ready(api_ready));

    api_sink api_sink_i (.clk(clk), .reset(reset), .api_out(api_out),
        .api_valid(api_valid), .api_ready(api_ready), .hold(hold),
        .slow(slow), .bad_frame(bad_frame));

    // ---------------------------------------------------------------
    // checking helpers
    // ---------------------------------------------------------------
    task automatic check(input string nm, input logic [8:0] e,
                         input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    function automatic logic [7:0] mcode(input logic [1:0] c,
                                         input logic e, input logic [6:0] k);
        if (e)
            return {1'b1, k};
        return c == 2'h0 ? 8'h00 : c == 2'h1 ? 8'h01 :
               c == 2'h2 ? 8'h40 : 8'h42;
    endfunction : mcode

    // expected frame: delimiter, length msb first, type, payload, sum
    task automatic exp_frame(input logic [7:0] typ, input logic [47:0] pl,
                             input int n);
        logic [7:0] s;
        s = typ;
        exp_q.push_back({8'h7e, 1'b0});
        exp_q.push_back(9'h000);
        exp_q.push_back({8'(n + 1), 1'b0});
        exp_q.push_back({typ, 1'b0});
        for (int i = n - 1; i >= 0; i--) begin
            exp_q.push_back({pl[i*8 +: 8], 1'b0});
            s = s + pl[i*8 +: 8];
        end
        exp_q.push_back({8'hff - s, 1'b1});
    endtask : exp_frame

    task automatic modem_case(input logic [1:0] c, input logic e,
                              input logic [6:0] k);
        int n;
        n = 0;
        exp_frame(8'h8a, {40'h0, mcode(c, e, k)}, 1);
        @(negedge clk);
        modem_cause = status_frame_pkg::modem_cause_e'(c);
        modem_stack_err = e;
        modem_stack_code = k;
        modem_evt = 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (modem_ready !== 1'b1 && n < 2000);
        @(negedge clk);
        modem_evt = 1'b0;
    endtask : modem_case

    task automatic tx_case(input status_frame_pkg::tx_done_s t);
        int n;
        logic [7:0] d;
        n = 0;
        d = t.broadcast ? 8'h00 : t.delivery;
        if (t.frame_id != 8'h00)
            exp_frame(8'h8b, {t.frame_id, 16'hfffe, t.retries, d,
                              t.route_disc ? 8'h02 : 8'h00}, 6);
        @(negedge clk);
        tx_info = t;
        tx_done = 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 2000);
        if (t.frame_id == 8'h00)
            check("drop wait", 9'h001, 9'(n));
        @(negedge clk);
        tx_done = 1'b0;
    endtask : tx_case

    task automatic wait_drain(input string nm);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        // let the host model settle its last checksum verdict
        @(negedge clk);
        check({nm, " left"}, 9'h000, 9'(exp_q.size()));
        check({nm, " frame"}, 9'h000, {8'h00, bad_frame});
        $display("test %s done", nm);
    endtask : wait_drain

    // ---------------------------------------------------------------
    // clock, stream compare, watchdog
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
        if (!reset && api_valid && api_ready)
            check("api byte", exp_q.size() ? exp_q.pop_front() : 9'h1ff,
                  api_out);

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        seed = 51;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        reset = 1'b1;
        hold = 1'b0;
        slow = 1'b0;
        modem_evt = 1'b0;
        modem_cause = status_frame_pkg::CAUSE_HW_RESET;
        modem_stack_err = 1'b0;
        modem_stack_code = 7'h00;
        tx_done = 1'b0;
        tx_info = '0;
        exp_frame(8'h8a, 48'h0, 1);
        repeat (10) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check("boot busy", 9'h000, {8'h00, modem_ready});
        wait_drain("boot");
        for (int c = 0; c < 4; c++)
            modem_case(2'(c), 1'b0, 7'h55);
        modem_case(2'h1, 1'b1, 7'h00);
        modem_case(2'h2, 1'b1, 7'h7f);
        wait_drain("modem");
        foreach (dtab[i])
            tx_case({8'(i+1), 1'b0, 8'(i), dtab[i], 1'(i)});
        tx_case({8'h5a, 1'b1, 8'h03, 8'h21, 1'b1});
        // idle builder, so the zero identifier meets an empty pipeline
        wait_drain("bcast");
        tx_case({8'h00, 1'b0, 8'h01, 8'h01, 1'b0});
        tx_case({8'hff, 1'b0, 8'hff, 8'h25, 1'b0});
        wait_drain("tx");
        fork
            modem_case(2'h3, 1'b0, 7'h00);
            begin
                #1;
                tx_case({8'h11, 1'b0, 8'h02, 8'h02, 1'b1});
            end
        join
        wait_drain("priority");
        hold = 1'b1;
        fork
            repeat (30)
                tx_case(26'($random(seed)));
            begin
                repeat (80) @(negedge clk);
                hold = 1'b0;
                slow = 1'b1;
            end
        join
        wait_drain("random");
        print_verdict();
    end
endmodule : tb_top
